// [bench/tbt_top_properties.sv]
// Checker for tbt_top: APB answer timing and periodic request timing.
// Sees only the top ports; ticks are assumed steady while enabled.
`timescale 1ns/1ps
`default_nettype none
module tbt_top_properties (
  input wire logic                      clock,
  input wire logic                      rst,
  input wire tbt_pkg::tbt_apb_req_type  apb_req,
  input wire tbt_pkg::tbt_apb_rsp_type  apb_rsp,
  input wire logic                      fast_tick,
  input wire logic                      slow_tick,
  input wire tbt_pkg::tbt_clk_mode_type clock_mode,
  input wire logic                      periodic_irq,
  input wire logic                      irq
);
  import tbt_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  localparam int TAP [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
  logic [2:0]  rate_reg;
  logic        src_reg;
  logic        en_reg;
  logic        msk_reg;
  logic        ok_reg;
  logic [1:0]  off_reg;
  logic [31:0] cnt_reg;
  logic [31:0] exp_n;
  // Shadow of the control byte and what it implies
  wire logic put = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready;
  wire logic cw = put & (apb_req.paddr == 8'hd8);
  wire logic slow_src = src_reg | clock_mode[1];
  wire logic live = en_reg & !(clock_mode[1] & (rate_reg > 3'h1));
  wire logic tick = slow_src ? slow_tick : fast_tick;
  wire logic unmapped = !(apb_req.paddr inside {8'hd8, 8'hdc, 8'he0, 8'he4});
  assign exp_n = slow_src ? (32'h1 << (TAP[rate_reg] - 7)) : (32'h1 << (TAP[rate_reg] + 1));
  ////////////////////////////////////////
  // Tick count since last request or control write; off_reg saturates
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {msk_reg, src_reg, en_reg, rate_reg} <= '0;
      cnt_reg <= '0;
      off_reg <= '0;
      ok_reg <= 1'b0;
    end else begin
      if (cw) {src_reg, en_reg, rate_reg} <= apb_req.pwdata[4:0];
      if (put && apb_req.paddr == 8'he0) msk_reg <= apb_req.pwdata[0];
      cnt_reg <= (periodic_irq || cw) ? {31'h0, tick} : cnt_reg + {31'h0, tick};
      ok_reg <= live && !cw && (ok_reg || periodic_irq);
      off_reg <= live ? 2'h0 : off_reg + {1'b0, off_reg != 2'h3};
    end
  end
  ////////////////////////////////////////
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence access_s;
    apb_req.psel && apb_req.penable;
  endsequence
  apb_wait_a: assert property ((setup_s ##1 access_s) |-> !apb_rsp.pready ##1
    (apb_rsp.pready && apb_rsp.pslverr == $past(unmapped))) else $error("apb answer wrong");
  ready_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready too long");
  reset_quiet_a: assert property ($fell(rst) |-> !apb_rsp.pready && !periodic_irq && !irq)
    else $error("output active after reset");
  pulse_once_a: assert property (periodic_irq |=> !periodic_irq)
    else $error("request longer than one cycle");
  quiet_off_a: assert property (off_reg == 2'h3 |-> !periodic_irq)
    else $error("request while stopped");
  period_a: assert property (periodic_irq && ok_reg |-> cnt_reg == exp_n)
    else $error("request period wrong");
  first_due_a: assert property (live |-> cnt_reg <= 2 * exp_n + 4)
    else $error("request overdue");
  irq_pend_a: assert property (periodic_irq && msk_reg |-> irq)
    else $error("irq not raised");
endmodule : tbt_top_properties
bind tbt_top tbt_top_properties i_props (.clock(clock), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .fast_tick(fast_tick), .slow_tick(slow_tick), .clock_mode(clock_mode),
  .periodic_irq(periodic_irq), .irq(irq));
`default_nettype wire

// [bench/tbt_top_tb.sv]
// Self-checking bench for tbt_top: register access, periods, interrupt flags.
// Ticks pulse every cycle so that periods stay short.
`timescale 1ns/1ps
`default_nettype none
module tbt_top_tb;
  import tbt_pkg::*;
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  tbt_apb_req_type  apb_req = '0;
  tbt_apb_rsp_type  apb_rsp;
  logic             fast_tick = 1'b0;
  logic             slow_tick = 1'b0;
  tbt_clk_mode_type clock_mode = TBT_MODE_NORMAL;
  logic             periodic_irq;
  logic             irq;
  int               n_fail = 0;
  int               n_tests = 0;
  int               n_pulse = 0;
  int               c;
  logic [31:0]      q;
  logic             e;
  // Settings measured: mode, control byte, period in cycles
  tbt_clk_mode_type md [10] = '{TBT_MODE_NORMAL, TBT_MODE_NORMAL, TBT_MODE_NORMAL,
    TBT_MODE_NORMAL, TBT_MODE_IDLE, TBT_MODE_NORMAL, TBT_MODE_IDLE, TBT_MODE_NORMAL,
    TBT_MODE_NORMAL, TBT_MODE_SLOW};
  logic [7:0] cb [10] = '{8'h0f, 8'h0e, 8'h0d, 8'h1f, 8'h1e, 8'h1d, 8'h1c, 8'h1b, 8'h1a, 8'h09};
  int per [10] = '{512, 2048, 4096, 2, 8, 16, 32, 64, 256, 8192};
  tbt_top i_tbt_top (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .fast_tick(fast_tick), .slow_tick(slow_tick), .clock_mode(clock_mode),
    .periodic_irq(periodic_irq), .irq(irq));
  always #10 clock = ~clock;
  // Request counter for quiet windows
  always @(posedge clock) n_pulse <= n_pulse + int'(periodic_irq);
  ////////////////////////////////////////
  task chk(input string n, input logic [31:0] x, input logic [31:0] s);
    n_tests++;
    if (s !== x) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One APB transfer; an edge passes first so psel never changes twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  // Cycles until the next request edge
  task wp;
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (periodic_irq !== 1'b1 && c < 40000);
  endtask : wp
  task close_out;
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Watchdog well above the expected run of about 30k cycles, under the 100k budget
  initial begin
    repeat (80000) @(posedge clock);
    n_fail++;
    close_out();
  end
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    fast_tick <= 1'b1;
    slow_tick <= 1'b1;
    apb(0, 8'hd8, 0); chk("ctrl reset", 0, q);
    apb(0, 8'hdc, 0); chk("status reset", 0, q);
    apb(1, 8'hd8, 32'h0000_00f7); apb(0, 8'hd8, 0); chk("ctrl rw", 32'h0000_00f7, q);
    apb(1, 8'hd8, 0);
    apb(0, 8'hfc, 0); chk("unmapped err", 1, {31'h0, e});
    chk("unmapped data", 0, q);
    apb(1, 8'he0, 1); apb(0, 8'he0, 0); chk("mask rw", 1, q);
    // Re-enable mid-period: divider keeps running, first request early
    apb(1, 8'hd8, 32'h0000_000f); wp; wp; chk("period", 512, c);
    apb(1, 8'hd8, 32'h0000_0007); repeat (4) @(posedge clock); c = n_pulse;
    repeat (200) @(posedge clock); chk("off quiet", c, n_pulse);
    apb(1, 8'hd8, 32'h0000_000f); wp; chk("early first", 1, c < 500);
    // Disable keeping the rate, then rate and enable in one write
    for (int i = 0; i < 10; i++) begin
      apb(0, 8'hd8, 0); apb(1, 8'hd8, q & 32'h0000_00f7);
      clock_mode <= md[i];
      apb(1, 8'hd8, {24'h0, cb[i]}); wp; wp; chk("period", per[i], c);
    end
    apb(1, 8'hd8, 32'h0000_0001);
    clock_mode <= TBT_MODE_SLEEP;
    apb(1, 8'hd8, 32'h0000_000a); repeat (4) @(posedge clock); c = n_pulse;
    repeat (600) @(posedge clock); chk("sleep quiet", c, n_pulse);
    apb(0, 8'hdc, 0); chk("bad flag", 2, q & 2);
    chk("irq on", 1, {31'h0, irq});
    apb(1, 8'he0, 0); repeat (2) @(posedge clock); chk("irq masked", 0, {31'h0, irq});
    apb(1, 8'hd8, 32'h0000_0002); apb(1, 8'hdc, 3); apb(0, 8'hdc, 0); chk("cleared", 0, q);
    close_out();
  end
endmodule : tbt_top_tb
`default_nettype wire

// [hw/tbt_divider.sv]
// Free-running divider chain with a selectable tap and falling-edge detector.
// Assumes fast_tick and slow_tick are one-cycle enables on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tbt_divider (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       fast_tick,
  input  wire logic       slow_tick,
  input  wire logic       slow_drive,
  input  wire logic       run,
  input  wire logic [2:0] rate,
  output logic            pulse,
  output logic            tap_level
);
  import tbt_pkg::*;

  tbt_div_state_type s_reg;
  tbt_div_state_type s_next;
  logic              carry;
  logic              tap;

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain; never cleared by software, only by chip reset
  always_comb begin
    s_next = s_reg;
    carry  = fast_tick && (&s_reg.count[`TBT_LOW_STAGES-1:0]);
    if (fast_tick) begin
      s_next.count[`TBT_LOW_STAGES-1:0] = s_reg.count[`TBT_LOW_STAGES-1:0] + 8'h01;
    end
    // Upper stages follow the slow tick when it drives them, else the carry
    if (slow_drive ? slow_tick : carry) begin
      s_next.count[`TBT_DIV_STAGES-1:`TBT_LOW_STAGES] =
        s_reg.count[`TBT_DIV_STAGES-1:`TBT_LOW_STAGES] + 15'h0001;
    end
    tap = s_reg.count[tbt_tap_index(rate)];
    s_next.tap_prev  = tap;
    s_next.rate_seen = rate;
    s_next.src_seen  = slow_drive;
    // A tap switch looks like an edge; the second cycle after any change is skipped, the first is not
    s_next.armed = run && (rate == s_reg.rate_seen) && (slow_drive == s_reg.src_seen);
    s_next.pulse = run && s_reg.armed && s_reg.tap_prev && !tap;
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pulse     = s_reg.pulse;
  assign tap_level = s_reg.tap_prev;
endmodule : tbt_divider
`default_nettype wire

// [hw/tbt_top.sv]
// Periodic time base timer: APB register slave, clock-mode tap steering,
// sticky event status with mask, and the periodic request toward the
// interrupt controller.
// Assumes fast_tick/slow_tick are one-cycle enables from the chip clock
// generator and clock_mode comes from the system controller, all on clock.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tbt_top (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire tbt_pkg::tbt_apb_req_type  apb_req,
  output var  tbt_pkg::tbt_apb_rsp_type  apb_rsp,
  input  wire logic                      fast_tick,
  input  wire logic                      slow_tick,
  input  wire tbt_pkg::tbt_clk_mode_type clock_mode,
  output logic                           periodic_irq,
  output logic                           irq
);
  import tbt_pkg::*;

  tbt_top_state_type s_reg;
  tbt_top_state_type s_next;

  logic        slow_now;
  logic        rate_ok;
  logic        run;
  logic        slow_drive;
  logic        div_pulse;
  logic        tap_level;
  logic        access;
  logic        hit;
  logic [31:0] rd_data;
  logic [1:0]  events;
  logic [1:0]  clear_bits;
  logic [7:0]  wr_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Rate steering

  // In slow and sleep the fast clock is stopped, so the slow tick drives
  // the upper stages regardless of the source bit.
  always_comb begin
    slow_now   = tbt_is_slow(clock_mode);
    slow_drive = s_reg.ctrl.divider_source_select || slow_now;
    // Codes above 001 have no rate in slow modes; hold off rather than guess
    rate_ok    = !slow_now || (s_reg.ctrl.periodic_rate_select[2:1] == 2'b00);
    run        = s_reg.ctrl.periodic_irq_enable && rate_ok;
  end

  // Divider chain and tap selection; the tap table maps both sources
  tbt_divider u_divider (
    .clock      (clock),
    .rst        (rst),
    .fast_tick  (fast_tick),
    .slow_tick  (slow_tick),
    .slow_drive (slow_drive),
    .run        (run),
    .rate       (s_reg.ctrl.periodic_rate_select),
    .pulse      (div_pulse),
    .tap_level  (tap_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  // Unmapped addresses read zero and answer with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    hit     = 1'b1;
    if (apb_req.paddr == tbt_byte_addr(`TBT_CTRL_IDX)) begin
      rd_data = {24'h00_0000, s_reg.ctrl};
    end else if (apb_req.paddr == tbt_byte_addr(`TBT_STATUS_IDX)) begin
      rd_data = {30'h0000_0000, s_reg.status};
    end else if (apb_req.paddr == tbt_byte_addr(`TBT_MASK_IDX)) begin
      rd_data = {30'h0000_0000, s_reg.mask};
    end else if (apb_req.paddr == tbt_byte_addr(`TBT_VIEW_IDX)) begin
      // Live view: running, tap level, slow clocking
      rd_data = {29'h0000_0000, run, tap_level, slow_now};
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake, register writes, events, request outputs

  always_comb begin
    s_next     = s_reg;
    access     = apb_req.psel && apb_req.penable;
    wr_byte    = apb_req.pwdata[7:0];
    clear_bits = 2'b00;

    // One wait state: pready rises the cycle after the access phase starts
    unique case (s_reg.apb_state)
      TBT_APB_WAIT: begin
        s_next.rsp.pready  = 1'b0;
        s_next.rsp.pslverr = 1'b0;
        if (access) begin
          s_next.rsp.pready  = 1'b1;
          s_next.rsp.pslverr = !hit;
          s_next.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_data;
          s_next.apb_state   = TBT_APB_DONE;
        end
      end
      TBT_APB_DONE: begin
        // The master samples pready here; writes land at this same edge
        s_next.rsp.pready  = 1'b0;
        s_next.rsp.pslverr = 1'b0;
        s_next.apb_state   = TBT_APB_WAIT;
        if (access && apb_req.pwrite && hit) begin
          if (apb_req.paddr == tbt_byte_addr(`TBT_CTRL_IDX)) begin
            // Whole byte at once, so rate and enable start together
            s_next.ctrl = tbt_ctrl_type'(wr_byte);
          end else if (apb_req.paddr == tbt_byte_addr(`TBT_STATUS_IDX)) begin
            clear_bits = wr_byte[1:0];
          end else if (apb_req.paddr == tbt_byte_addr(`TBT_MASK_IDX)) begin
            s_next.mask = wr_byte[1:0];
          end
        end
      end
    endcase

    // Rate changes while enabled are software's burden; hardware disarms
    // the edge detector one cycle late, so a tap switch while enabled can fake an edge.

    // Events: a periodic request, and an enable left on an invalid slow code
    events = 2'b00;
    events[`TBT_ST_TICK_BIT] = div_pulse && s_next.ctrl.periodic_irq_enable;
    events[`TBT_ST_BAD_BIT]  = s_reg.ctrl.periodic_irq_enable && !rate_ok;

    // Write-one-to-clear, with a same-cycle event winning over the clear
    s_next.status = (s_reg.status & ~clear_bits) | events;

    // Pulse is gated by the enable that stands after this edge, so a
    // disable write cannot let a late request through.
    s_next.periodic_irq = div_pulse && s_next.ctrl.periodic_irq_enable;
    s_next.irq          = |(s_next.status & s_next.mask);
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg           <= '0;
      s_reg.ctrl      <= tbt_ctrl_type'(`TBT_CTRL_RESET);
      s_reg.status    <= `TBT_FLAG_RESET;
      s_reg.mask      <= `TBT_FLAG_RESET;
      s_reg.apb_state <= TBT_APB_WAIT;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign apb_rsp      = s_reg.rsp;
  assign periodic_irq = s_reg.periodic_irq;
  assign irq          = s_reg.irq;
endmodule : tbt_top
`default_nettype wire

// [shared/tbt_pkg.sv]
// Types and helper functions shared by the time base timer modules.
// Assumes tbt_regs.svh is on the include path.
`default_nettype none
package tbt_pkg;
  `include "tbt_regs.svh"

  // Chip clock mode reported by the system controller
  typedef enum logic [1:0] {
    TBT_MODE_NORMAL = 2'b00,
    TBT_MODE_IDLE   = 2'b01,
    TBT_MODE_SLOW   = 2'b10,
    TBT_MODE_SLEEP  = 2'b11
  } tbt_clk_mode_type;

  // Control byte, bit 7 down to bit 0
  typedef struct packed {
    logic       buzzer_out_enable;
    logic [1:0] buzzer_rate_select;
    logic       divider_source_select;
    logic       periodic_irq_enable;
    logic [2:0] periodic_rate_select;
  } tbt_ctrl_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tbt_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tbt_apb_rsp_type;

  typedef enum logic {
    TBT_APB_WAIT = 1'b0,
    TBT_APB_DONE = 1'b1
  } tbt_apb_state_type;

  typedef struct packed {
    logic [`TBT_DIV_STAGES-1:0] count;
    logic [2:0]                 rate_seen;
    logic                       src_seen;
    logic                       tap_prev;
    logic                       armed;
    logic                       pulse;
  } tbt_div_state_type;

  typedef struct packed {
    tbt_ctrl_type      ctrl;
    tbt_apb_state_type apb_state;
    tbt_apb_rsp_type   rsp;
    logic [1:0]        status;
    logic [1:0]        mask;
    logic              periodic_irq;
    logic              irq;
  } tbt_top_state_type;

  // Rate code to divider bit
  function automatic logic [4:0] tbt_tap_index(input logic [2:0] rate);
    logic [4:0] idx;
    unique case (rate)
      3'b000: idx = `TBT_TAP_000;
      3'b001: idx = `TBT_TAP_001;
      3'b010: idx = `TBT_TAP_010;
      3'b011: idx = `TBT_TAP_011;
      3'b100: idx = `TBT_TAP_100;
      3'b101: idx = `TBT_TAP_101;
      3'b110: idx = `TBT_TAP_110;
      3'b111: idx = `TBT_TAP_111;
    endcase
    return idx;
  endfunction : tbt_tap_index

  // Register index to APB byte address
  function automatic logic [7:0] tbt_byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : tbt_byte_addr

  function automatic logic tbt_is_slow(input tbt_clk_mode_type mode);
    return (mode == TBT_MODE_SLOW) || (mode == TBT_MODE_SLEEP);
  endfunction : tbt_is_slow
endpackage : tbt_pkg
`default_nettype wire

// [shared/tbt_regs.svh]
// Register indices, field positions, reset values and divider tap positions
// for the periodic time base timer. Definitions only; included by bare name.
`ifndef TBT_REGS_SVH
`define TBT_REGS_SVH

// Register indices; the APB byte address is four times the index
`define TBT_CTRL_IDX      8'h36
`define TBT_STATUS_IDX    8'h37
`define TBT_MASK_IDX      8'h38
`define TBT_VIEW_IDX      8'h39

// Reset values
`define TBT_CTRL_RESET    8'h00
`define TBT_FLAG_RESET    2'b00

// Field positions inside the control byte
`define TBT_BUZ_EN_BIT    7
`define TBT_BUZ_RATE_LSB  5
`define TBT_DIV_SRC_BIT   4
`define TBT_EN_BIT        3
`define TBT_RATE_LSB      0

// Sticky event positions in status and mask
`define TBT_ST_TICK_BIT   0
`define TBT_ST_BAD_BIT    1

// Divider bit k toggles at input / 2^(k+1); low 8 stages run on the fast tick
`define TBT_LOW_STAGES    8
`define TBT_DIV_STAGES    23
`define TBT_TAP_000       5'd22
`define TBT_TAP_001       5'd20
`define TBT_TAP_010       5'd15
`define TBT_TAP_011       5'd13
`define TBT_TAP_100       5'd12
`define TBT_TAP_101       5'd11
`define TBT_TAP_110       5'd10
`define TBT_TAP_111       5'd8

`endif
